// ===== inc/shpes_cfg.svh
// Constants for the slot hot-plug event and status block
// Summary of operation
// R1 - Presence-change enable gates presence notification
// R2 - Latch-sensor enable gates latch notification
// R3 - Latch enable reads zero without sensor
// R4 - Power-fault enable gates power-fault notification
// R5 - Power-fault enable zero when unsupported
// R6 - Button enable gates button notification
// R7 - Present state is in-band OR out-of-band
// R8 - Present state zero empty, one present
// R9 - No slot implemented: present reads one
// R10 - Presence change sets sticky changed flag
// R11 - Latch change sets flag only if sensor
// R12 - Power fault sets flag whenever supported
// R13 - Button press sets flag only if button
// R14 - Write one clears flag; reserved read zero
// R15 - Notify on new flag or late enable (code pulses only when no other armed flag is already set)
`ifndef SHPES_CFG_SVH
`define SHPES_CFG_SVH
`define SHPES_STS_OFFSET  8'hBA
`define SHPES_CTL_OFFSET  8'hB8
`define SHPES_BIT_BUTTON  0
`define SHPES_BIT_PFAULT  1
`define SHPES_BIT_LATCH   2
`define SHPES_BIT_PRES    3
`define SHPES_BIT_PSTATE  6
`define SHPES_STS_RESET   16'h0000
`define SHPES_EN_RESET    4'h0
`define SHPES_FLAG_RESET  4'h0
`define SHPES_CTL_RESET   16'h0000
`define SHPES_PIN_RESET   5'h00
`define SHPES_ST_RESET    1'b0
`endif

// ===== inc/shpes_pkg.sv
// Types for the slot hot-plug event and status block
package shpes_pkg;
  typedef struct packed {
    logic presence;
    logic latch;
    logic pfault;
    logic button;
  } shpes_evt_t;
endpackage : shpes_pkg

// ===== hdl/shpes_top.sv
// Slot hot-plug enables, sticky event flags and notification
`timescale 1ns/1ns
`include "shpes_cfg.svh"
module shpes_top
  import shpes_pkg::*;
#(
  parameter bit SLOT_IMPL    = 1'b1,
  parameter bit LATCH_IMPL   = 1'b1,
  parameter bit PFAULT_IMPL  = 1'b1,
  parameter bit BUTTON_IMPL  = 1'b1
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        INBAND_PRESENT,
  input  wire logic        OOB_PRESENT,
  input  wire logic        LATCH_SENSOR,
  input  wire logic        POWER_FAULT,
  input  wire logic        BUTTON,
  input  wire logic        CFG_WR,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [15:0] CFG_WDATA,
  output logic      [15:0] CFG_RDATA,
  output logic             NOTIFY
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Two stages per pin: sensors and the button are not on CORE_CLK
  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  logic [4:0] nxt_s1;
  logic [4:0] nxt_s2;
  logic [4:0] prev_ff, nxt_prev;
  always_comb begin
    nxt_s1 = {INBAND_PRESENT, OOB_PRESENT, LATCH_SENSOR, POWER_FAULT,
              BUTTON};
    nxt_s2 = s1_ff;
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s1_ff <= `SHPES_PIN_RESET;
      s2_ff <= `SHPES_PIN_RESET;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  // ************************************************************
  // Event detection
  // ************************************************************
  logic       present;
  shpes_evt_t evt;
  logic [4:0] cur;
  always_comb begin
    present = SLOT_IMPL ? (s2_ff[4] | s2_ff[3]) : 1'b1; // R7 R8 R9
    // Bit 3 only pads the word; bits 4, 2 and 0 are compared, bit 1 is used as a level
    cur     = {present, s2_ff[3:0]};
    nxt_prev = cur;
    evt.presence = SLOT_IMPL && (cur[4] != prev_ff[4]); // R10
    evt.latch    = LATCH_IMPL && (cur[2] != prev_ff[2]); // R11
    // Level fault: flag re-sets while fault persists after clear
    evt.pfault   = PFAULT_IMPL && cur[1]; // R12
    evt.button   = BUTTON_IMPL && cur[0] && !prev_ff[0]; // R13
  end
  // Reset seeds "present" high only when SLOT_IMPL is 0, so a slotless port sees no edge
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      prev_ff <= {!SLOT_IMPL, 4'h0};
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // ************************************************************
  // Write decode
  // ************************************************************
  logic wr_sts;
  logic wr_ctl;
  always_comb begin
    wr_sts = CFG_WR && (CFG_ADDR == `SHPES_STS_OFFSET);
    wr_ctl = CFG_WR && (CFG_ADDR == `SHPES_CTL_OFFSET);
  end

  // ************************************************************
  // Notification enables
  // ************************************************************
  shpes_evt_t en_ff;
  shpes_evt_t nxt_en;
  shpes_evt_t wen;
  always_comb begin
    wen.presence = CFG_WDATA[`SHPES_BIT_PRES]; // R1
    // No sensor: enable held at zero so a write cannot arm it
    wen.latch    = LATCH_IMPL && CFG_WDATA[`SHPES_BIT_LATCH]; // R2 R3
    wen.pfault   = PFAULT_IMPL && CFG_WDATA[`SHPES_BIT_PFAULT]; // R4 R5
    wen.button   = CFG_WDATA[`SHPES_BIT_BUTTON]; // R6
    nxt_en       = en_ff;
    if (wr_ctl) begin
      nxt_en = wen;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      en_ff <= `SHPES_EN_RESET;
    end else begin
      en_ff <= nxt_en;
    end
  end

  // ************************************************************
  // Sticky event flags
  // ************************************************************
  shpes_evt_t flag_ff;
  shpes_evt_t nxt_flag;
  shpes_evt_t clr;
  always_comb begin
    clr.presence = wr_sts && CFG_WDATA[`SHPES_BIT_PRES]; // R14
    clr.latch    = wr_sts && CFG_WDATA[`SHPES_BIT_LATCH];
    clr.pfault   = wr_sts && CFG_WDATA[`SHPES_BIT_PFAULT];
    clr.button   = wr_sts && CFG_WDATA[`SHPES_BIT_BUTTON];
    // Set beats a same-cycle clear, so no event is lost
    nxt_flag = evt | (flag_ff & ~clr); // R10 R11 R12 R13
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      flag_ff <= `SHPES_FLAG_RESET;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ************************************************************
  // Card-present state
  // ************************************************************
  logic st_ff;
  logic nxt_st;
  always_comb begin
    nxt_st = present; // R7 R8 R9
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_ff <= `SHPES_ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Notification pulse
  // ************************************************************
  logic pend;
  logic pend_d_ff;
  logic nxt_pend_d;
  logic notify_ff;
  logic nxt_notify;
  always_comb begin
    pend       = |(flag_ff & en_ff); // R1 R2 R4 R6
    nxt_pend_d = pend;
    // Edge of the OR also covers a late enable; a second flag while
    // another armed flag stays set gives no new pulse
    nxt_notify = pend && !pend_d_ff; // R15
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pend_d_ff <= 1'b0;
      notify_ff <= 1'b0;
    end else begin
      pend_d_ff <= nxt_pend_d;
      notify_ff <= nxt_notify;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Registered read: one cycle after the address, eases timing
  logic [15:0] sts_word;
  logic [15:0] ctl_word;
  logic [15:0] rd_ff;
  logic [15:0] nxt_rd;
  always_comb begin
    sts_word = `SHPES_STS_RESET; // R14
    sts_word[`SHPES_BIT_PSTATE] = st_ff; // R8
    sts_word[`SHPES_BIT_PRES]   = flag_ff.presence;
    sts_word[`SHPES_BIT_LATCH]  = flag_ff.latch;
    sts_word[`SHPES_BIT_PFAULT] = flag_ff.pfault;
    sts_word[`SHPES_BIT_BUTTON] = flag_ff.button;
    ctl_word = `SHPES_CTL_RESET;
    ctl_word[`SHPES_BIT_PRES]   = en_ff.presence;
    ctl_word[`SHPES_BIT_LATCH]  = en_ff.latch;
    ctl_word[`SHPES_BIT_PFAULT] = en_ff.pfault;
    ctl_word[`SHPES_BIT_BUTTON] = en_ff.button;
    case (CFG_ADDR)
      `SHPES_STS_OFFSET: begin
        nxt_rd = sts_word;
      end
      `SHPES_CTL_OFFSET: begin
        nxt_rd = ctl_word;
      end
      // Unmapped offsets read zero
      default: begin
        nxt_rd = `SHPES_STS_RESET;
      end
    endcase
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rd_ff <= `SHPES_STS_RESET;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  // Both outputs come straight from flip-flops
  assign CFG_RDATA = rd_ff;
  assign NOTIFY    = notify_ff;
endmodule : shpes_top

// ===== testbench/shpes_chk_checker.sv
// Port assertions for the slot hot-plug block
`timescale 1ns/1ns
module shpes_chk (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        INBAND_PRESENT,
  input wire logic        OOB_PRESENT,
  input wire logic        POWER_FAULT,
  input wire logic        BUTTON,
  input wire logic        CFG_WR,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic [15:0] CFG_RDATA,
  input wire logic        NOTIFY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence s_rd;
    CFG_ADDR == 8'hBA && !CFG_WR;
  endsequence
  a_rsv_zero: assert property (CFG_ADDR == 8'hBA |=>
    !CFG_RDATA[15:7] && !CFG_RDATA[5:4]) else $error("rsv");
  a_unmapped_zero: assert property (CFG_ADDR[7:3] != 5'h17 |=>
    CFG_RDATA == 16'h0000) else $error("unmapped");
  a_notify_pulse: assert property (NOTIFY |=> !NOTIFY)
    else $error("notify");
  a_present_or: assert property (
    ((INBAND_PRESENT || OOB_PRESENT) && CFG_ADDR == 8'hBA)[*6]
    |-> CFG_RDATA[6]) else $error("present");
  a_empty_state: assert property (
    (!INBAND_PRESENT && !OOB_PRESENT && CFG_ADDR == 8'hBA)[*6]
    |-> !CFG_RDATA[6]) else $error("empty");
  a_button_sets: assert property ($rose(BUTTON) ##1 s_rd[*5]
    |-> CFG_RDATA[0]) else $error("button");
  // Fault is a level, so a clearing write cannot hide it
  a_fault_sets: assert property (
    (POWER_FAULT && CFG_ADDR == 8'hBA)[*6] |-> CFG_RDATA[1])
    else $error("fault");
  a_flag_sticky: assert property (CFG_RDATA[3] && !CFG_WR &&
    !$past(CFG_WR) && $past(CFG_ADDR) == 8'hBA && CFG_ADDR == 8'hBA
    |=> CFG_RDATA[3]) else $error("sticky");
endmodule : shpes_chk
bind shpes_top shpes_chk u_chk (.*);

// ===== testbench/shpes_slot.sv
// Slot adapter and sensors: {inband, oob, latch, fault, button}
`timescale 1ns/1ns
module shpes_slot (
  input  wire logic       clk,
  output logic      [4:0] pins
);
  initial pins = 5'h00;
  // Delay in cycles lets a sensor answer late
  task automatic move(input logic [4:0] v, input int dly);
    repeat (dly + 1) @(posedge clk);
    #1 pins = v;
  endtask : move
endmodule : shpes_slot

// ===== testbench/tb_top.sv
// Self-checking bench for the slot hot-plug block
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic        clk, rst, wr, ntf;
  logic [7:0]  adr;
  logic [15:0] wd, rd;
  logic [4:0]  p;
  int          err_total, n_tests, n_ntf;
  shpes_slot u_slot (.clk(clk), .pins(p));
  shpes_top u_dut (.CORE_CLK(clk), .RESET(rst), .INBAND_PRESENT(p[4]),
    .OOB_PRESENT(p[3]), .LATCH_SENSOR(p[2]), .POWER_FAULT(p[1]),
    .BUTTON(p[0]), .CFG_WR(wr), .CFG_ADDR(adr), .CFG_WDATA(wd),
    .CFG_RDATA(rd), .NOTIFY(ntf));
  initial begin clk = 0; forever #2 clk = ~clk; end
  always @(posedge clk) if (ntf === 1'b1) n_ntf++;
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #1 {wr, adr, wd} = {1'b1, a, d};
    @(posedge clk) #1 wr = 1'b0;
  endtask : w
  task automatic r(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk) #1 adr = a;
    @(posedge clk) #1 `CHK(rd, e)
  endtask : r
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    {rst, wr, adr, wd} = {1'b1, 1'b0, 8'hBA, 16'h0000};
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    r(8'hBA, 16'h0000);
    r(8'hB8, 16'h0000);
    w(8'h40, 16'hFFFF);
    r(8'h40, 16'h0000);
    w(8'hB8, 16'h000F);
    r(8'hB8, 16'h000F);
    r(8'hBA, 16'h0000);
    $display("test 1 end");
    u_slot.move(5'h10, 0);
    repeat (8) @(posedge clk);
    r(8'hBA, 16'h0048);
    `CHK(n_ntf, 1)
    w(8'hBA, 16'h0000);
    r(8'hBA, 16'h0048);
    w(8'hBA, 16'h0008);
    r(8'hBA, 16'h0040);
    u_slot.move(5'h08, 3);
    w(8'hB8, 16'h0000);
    r(8'hBA, 16'h0040);
    $display("test 2 end");
    u_slot.move(5'h0F, 2);
    repeat (8) @(posedge clk);
    r(8'hBA, 16'h0047);
    `CHK(n_ntf, 1)
    w(8'hB8, 16'h0001);
    repeat (3) @(posedge clk);
    `CHK(n_ntf, 2)
    u_slot.move(5'h00, 1);
    repeat (8) @(posedge clk);
    r(8'hBA, 16'h000F);
    w(8'hBA, 16'h000F);
    r(8'hBA, 16'h0000);
    $display("test 3 end");
    give_verdict();
  end
endmodule : tb_top
